// ==== src/pfm_top.sv ====
// Power fault monitor with fault-code blinker and lamp driver, AXI4-Lite controlled.
// Assumes rail power-good pins are asynchronous and software mirrors platform state.
`timescale 1ns/100ps
`default_nettype none
`include "pfm_map.svh"

module pfm_top
    import pfm_pkg::*;
#(
    parameter int CYC_PER_MS = `PFM_CLK_KHZ
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Register bus.
    input wire pfm_axi_req_t axi_req,
    output pfm_axi_rsp_t axi_rsp,
    // Rail power-good pins.
    input wire logic first_rail_power_good,
    input wire logic second_rail_power_good,
    input wire logic third_rail_power_good,
    // Rail enable and lamps.
    output logic rail_enable_request,
    output logic supply_charge_lamp_white,
    output logic supply_charge_lamp_amber,
    output logic power_lamp_white
);

    localparam int PW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;

    if (CYC_PER_MS < 2) begin : g_bad_rate
        $error("CYC_PER_MS must be at least 2");
    end

    function automatic logic [8:0] pick_fault(input logic [10:0] ev);
        logic [8:0] r;
        r = 9'h000;
        for (int i = 10; i >= 0; i--) begin
            if (ev[i]) begin
                unique case (i)
                    0: r = {1'b1, `PFM_CODE_R1_SEQ};
                    1: r = {1'b1, `PFM_CODE_R1_ON};
                    2: r = {1'b1, `PFM_CODE_R1_ARMED};
                    3: r = {1'b1, `PFM_CODE_R1_S5};
                    4: r = {1'b1, `PFM_CODE_R2_SEQ};
                    5: r = {1'b1, `PFM_CODE_R2_ON};
                    6: r = {1'b1, `PFM_CODE_R2_ARMED};
                    7: r = {1'b1, `PFM_CODE_R2_S5};
                    8: r = {1'b1, `PFM_CODE_R3_SEQ};
                    9: r = {1'b1, `PFM_CODE_R3_ON};
                    default: r = {1'b1, `PFM_CODE_R3_S5};
                endcase
            end
        end
        return r;
    endfunction

    // Register state.
    logic [7:0] ctrl_q;
    pfm_axi_rsp_t rsp_q;
    logic aw_held_q, w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic w_strb0_q;

    // Pin synchronisers and filtered levels.
    logic [2:0] s1_q, s2_q, s3_q, pg_q;
    logic [PW-1:0] pre_q;
    logic tick_q;
    logic [10:0] tmo_q [3];

    // Fault latch and blinker.
    logic fault_q;
    logic [7:0] code_q;
    pfm_blink_t bl_q;
    logic [2:0] bit_q;
    logic [10:0] dur_q;
    logic [10:0] flash_cnt_q;
    logic flash_q;
    logic white_q, amber_q, plamp_q;

    // Write path: address and data in either order, response after both.
    wire aw_take = axi_req.awvalid && rsp_q.awready;
    wire w_take = axi_req.wvalid && rsp_q.wready;
    wire do_write = aw_held_q && w_held_q && !rsp_q.bvalid;
    wire wr_ctrl = do_write && aw_addr_q == `PFM_OFS_CTRL;
    wire wr_ok = aw_addr_q == `PFM_OFS_CTRL || aw_addr_q == `PFM_OFS_STATUS;
    wire ar_take = axi_req.arvalid && rsp_q.arready;
    wire [7:0] ar_ofs = axi_req.araddr[7:0];
    wire rd_ok = ar_ofs == `PFM_OFS_CTRL || ar_ofs == `PFM_OFS_STATUS;
    wire [31:0] status_w = {20'h00000, pg_q, fault_q, code_q};
    wire [31:0] rd_data = (ar_ofs == `PFM_OFS_CTRL) ? {24'h000000, ctrl_q} :
                          (ar_ofs == `PFM_OFS_STATUS) ? status_w : 32'h00000000;

    always_ff @(posedge clock) begin
        if (srst) begin
            rsp_q <= '0;
            rsp_q.awready <= 1'b1;
            rsp_q.wready <= 1'b1;
            rsp_q.arready <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb0_q <= 1'b0;
            ctrl_q <= `PFM_CTRL_RST;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= axi_req.awaddr[7:0];
                rsp_q.awready <= 1'b0;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                w_data_q <= axi_req.wdata;
                w_strb0_q <= axi_req.wstrb[0];
                rsp_q.wready <= 1'b0;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                rsp_q.bvalid <= 1'b1;
                rsp_q.bresp <= wr_ok ? `PFM_RESP_OKAY : `PFM_RESP_SLVERR;
                if (wr_ctrl && w_strb0_q) begin
                    ctrl_q <= w_data_q[7:0];
                end
            end
            if (rsp_q.bvalid && axi_req.bready) begin
                rsp_q.bvalid <= 1'b0;
                rsp_q.awready <= 1'b1;
                rsp_q.wready <= 1'b1;
            end
            if (ar_take) begin
                rsp_q.arready <= 1'b0;
                rsp_q.rvalid <= 1'b1;
                rsp_q.rdata <= rd_data;
                rsp_q.rresp <= rd_ok ? `PFM_RESP_OKAY : `PFM_RESP_SLVERR;
            end
            if (rsp_q.rvalid && axi_req.rready) begin
                rsp_q.rvalid <= 1'b0;
                rsp_q.arready <= 1'b1;
            end
        end
    end

    // Software mirrors of platform and charger status.
    wire pfm_pwr_state_t pstate = pfm_pwr_state_t'(ctrl_q[`PFM_F_STATE_LO +: 2]);
    wire adapter = ctrl_q[`PFM_F_ADAPTER];
    wire charging = ctrl_q[`PFM_F_CHARGING];
    wire full = ctrl_q[`PFM_F_FULL];
    wire batt_low = ctrl_q[`PFM_F_BATT_LOW];
    wire rail_en = ctrl_q[`PFM_F_RAIL_EN];
    wire batt_present = ctrl_q[`PFM_F_BATT_PRESENT];

    // A level counts once the second and third stages agree, filtering runt glitches.
    wire [3-1:0] pg_pins = {third_rail_power_good, second_rail_power_good, first_rail_power_good};
    wire [2:0] pg_new = (s2_q & s3_q) | (pg_q & (s2_q | s3_q));
    wire [2:0] pg_rise = pg_new & ~pg_q;
    wire [2:0] pg_fall = pg_q & ~pg_new;
    wire in_seq = pstate == PFM_PWR_SEQUENCE && rail_en;
    wire in_on = pstate == PFM_PWR_ON;
    wire in_armed = pstate == PFM_PWR_WAKE_ARMED;
    wire in_s5 = pstate == PFM_PWR_SOFT_OFF;
    wire [2:0] tmo_hit;
    for (genvar r = 0; r < 3; r++) begin : g_tmo
        assign tmo_hit[r] = in_seq && !pg_q[r] && tick_q && tmo_q[r] == `PFM_PG_TIMEOUT_MS;
    end

    // Fault events, lowest index wins when several arrive together.
    // sequence timeouts and state edge faults.
    wire [10:0] events = {
        pg_rise[2] && in_s5, pg_fall[2] && in_on, tmo_hit[2],
        pg_rise[1] && in_s5, pg_fall[1] && in_armed, pg_fall[1] && in_on, tmo_hit[1],
        pg_rise[0] && in_s5, pg_fall[0] && in_armed, pg_fall[0] && in_on, tmo_hit[0]
    };
    wire [8:0] picked = pick_fault(events);
    wire power_gone = !adapter && !batt_present;

    always_ff @(posedge clock) begin
        if (srst) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            s3_q <= 3'h0;
            pg_q <= 3'h0;
            pre_q <= '0;
            tick_q <= 1'b0;
            tmo_q <= '{default: 11'h000};
            fault_q <= 1'b0;
            code_q <= 8'h00;
        end else begin
            s1_q <= pg_pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pg_q <= pg_new;
            tick_q <= pre_q == PW'(CYC_PER_MS - 1);
            pre_q <= (pre_q == PW'(CYC_PER_MS - 1)) ? '0 : pre_q + 1'b1;
            for (int r = 0; r < 3; r++) begin
                if (!in_seq || pg_q[r]) begin
                    tmo_q[r] <= 11'h000;
                end else if (tick_q && tmo_q[r] != `PFM_PG_TIMEOUT_MS) begin
                    tmo_q[r] <= tmo_q[r] + 11'h001;
                end
            end
            // latch until adapter and battery are both gone; a new event wins over the clear.
            if (picked[8] && !fault_q) begin
                fault_q <= 1'b1;
                code_q <= picked[7:0];
            end else if (power_gone && !picked[8]) begin
                fault_q <= 1'b0;
            end
        end
    end

    // Blink phase lengths in milliseconds.
    wire code_bit = code_q[bit_q];
    wire [10:0] phase_len = (bl_q == PFM_BL_START) ? `PFM_START_MS :
                            (bl_q == PFM_BL_GAP) ? `PFM_GAP_MS :
                            code_bit ? `PFM_ONE_MS : `PFM_ZERO_MS;
    wire phase_end = tick_q && dur_q == phase_len - 11'h001;

    always_ff @(posedge clock) begin
        if (srst || !fault_q) begin
            bl_q <= PFM_BL_IDLE;
            bit_q <= 3'h0;
            dur_q <= 11'h000;
        end else begin
            if (tick_q) begin
                dur_q <= phase_end ? 11'h000 : dur_q + 11'h001;
            end
            unique case (bl_q)
                PFM_BL_IDLE: begin
                    bl_q <= PFM_BL_START;
                    dur_q <= 11'h000;
                end
                PFM_BL_START: begin
                    if (phase_end) begin
                        bl_q <= PFM_BL_ON;
                        bit_q <= 3'h0;
                    end
                end
                PFM_BL_ON: begin
                    if (phase_end) begin
                        bl_q <= PFM_BL_GAP;
                    end
                end
                PFM_BL_GAP: begin
                    if (phase_end) begin
                        bl_q <= (bit_q == 3'h7) ? PFM_BL_START : PFM_BL_ON;
                        bit_q <= bit_q + 3'h1;
                    end
                end
            endcase
        end
    end

    // Lamp outputs; the flash phase runs free so low-battery flashing is even.
    wire steady_amber = adapter && charging && !full;
    wire steady_white = adapter && full;
    wire low_flash = batt_low && !adapter;
    always_ff @(posedge clock) begin
        if (srst) begin
            flash_cnt_q <= 11'h000;
            flash_q <= 1'b0;
            white_q <= 1'b0;
            amber_q <= 1'b0;
            plamp_q <= 1'b0;
        end else begin
            if (tick_q) begin
                flash_cnt_q <= (flash_cnt_q == `PFM_FLASH_MS - 11'h001) ? 11'h000 :
                               flash_cnt_q + 11'h001;
                flash_q <= (flash_cnt_q == `PFM_FLASH_MS - 11'h001) ? !flash_q : flash_q;
            end
            white_q <= fault_q ? (bl_q == PFM_BL_ON) : steady_white;
            amber_q <= !fault_q && (steady_amber || (low_flash && flash_q));
            plamp_q <= in_on && (adapter || batt_present);
        end
    end

    assign axi_rsp = rsp_q;
    assign rail_enable_request = ctrl_q[`PFM_F_RAIL_EN];
    assign supply_charge_lamp_white = white_q;
    assign supply_charge_lamp_amber = amber_q;
    assign power_lamp_white = plamp_q;

    // Ticks the lamp has stood lit, counted apart from the blinker's own timer.
    logic [10:0] lit_ms_q;
    always_ff @(posedge clock) begin
        if (srst || !white_q) begin
            lit_ms_q <= 11'h000;
        end else if (tick_q) begin
            lit_ms_q <= lit_ms_q + 11'h001;
        end
    end

    a_amber_steady: assert property (@(posedge clock) disable iff (srst)
        (!fault_q && steady_amber) |=> (amber_q && !white_q))
        else $error("amber lamp not steady while charging");
    a_white_steady: assert property (@(posedge clock) disable iff (srst)
        (!fault_q && steady_white) |=> (white_q && !amber_q))
        else $error("white lamp not steady at full charge");
    a_lamps_dark: assert property (@(posedge clock) disable iff (srst)
        (!fault_q && !steady_amber && !steady_white && !low_flash) |=> (!white_q && !amber_q))
        else $error("supply lamp lit with no condition");
    a_power_lamp: assert property (@(posedge clock) disable iff (srst)
        (pstate != PFM_PWR_ON) |=> !power_lamp_white)
        else $error("power lamp lit while not on");
    a_start_dark: assert property (@(posedge clock) disable iff (srst)
        (bl_q == PFM_BL_START && fault_q) |=> !white_q)
        else $error("lamp lit during start interval");
    a_frame_bits: assert property (@(posedge clock) disable iff (srst)
        (bl_q == PFM_BL_GAP && phase_end && fault_q) |=>
        (bl_q == (($past(bit_q) == 3'h7) ? PFM_BL_START : PFM_BL_ON)))
        else $error("wrong frame sequence after gap");
    a_bit_length: assert property (@(posedge clock) disable iff (srst)
        (fault_q && bl_q == PFM_BL_GAP && $fell(white_q)) |->
        (lit_ms_q == (code_bit ? `PFM_ONE_MS : `PFM_ZERO_MS)))
        else $error("bit on time wrong");
    a_seq_timeout: assert property (@(posedge clock) disable iff (srst)
        (!fault_q && tmo_hit[0]) |=> (fault_q && code_q == `PFM_CODE_R1_SEQ))
        else $error("first rail timeout not reported");
    a_on_drop: assert property (@(posedge clock) disable iff (srst)
        (!fault_q && in_on && pg_fall[0]) |=> (fault_q && code_q == `PFM_CODE_R1_ON))
        else $error("first rail drop not reported");
    a_fault_holds: assert property (@(posedge clock) disable iff (srst)
        (fault_q && !power_gone) |=> (fault_q && $stable(code_q)))
        else $error("latched fault lost");
    a_fault_amber: assert property (@(posedge clock) disable iff (srst)
        fault_q |=> !amber_q)
        else $error("amber lamp lit during fault code");
    a_armed_drop: assert property (@(posedge clock) disable iff (srst)
        (!fault_q && in_armed && pg_fall[0]) |=> (fault_q && code_q == `PFM_CODE_R1_ARMED))
        else $error("first rail drop while armed not reported");
    a_off_rise: assert property (@(posedge clock) disable iff (srst)
        (!fault_q && in_s5 && pg_rise[0]) |=> (fault_q && code_q == `PFM_CODE_R1_S5))
        else $error("first rail rise in soft-off not reported");
    a_second_drop: assert property (@(posedge clock) disable iff (srst)
        (!fault_q && in_on && pg_fall[1] && !pg_fall[0]) |=>
        (fault_q && code_q == `PFM_CODE_R2_ON))
        else $error("second rail drop not reported");
    a_third_rise: assert property (@(posedge clock) disable iff (srst)
        (!fault_q && in_s5 && pg_rise == 3'b100) |=> (fault_q && code_q == `PFM_CODE_R3_S5))
        else $error("third rail rise in soft-off not reported");

endmodule // pfm_top
`default_nettype wire

// ==== src/pfm_map.svh ====
// Register offsets, field positions, reset values, fault codes and blink timing.
// Assumes a 10 MHz clock; long phases are counted in milliseconds.
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH

`define PFM_OFS_CTRL 8'h00
`define PFM_OFS_STATUS 8'h04
`define PFM_CTRL_RST 8'h00

`define PFM_F_STATE_LO 0
`define PFM_F_ADAPTER 2
`define PFM_F_CHARGING 3
`define PFM_F_FULL 4
`define PFM_F_BATT_LOW 5
`define PFM_F_RAIL_EN 6
`define PFM_F_BATT_PRESENT 7

`define PFM_F_LATCHED 8
`define PFM_F_PG_LO 9

`define PFM_RESP_OKAY 2'b00
`define PFM_RESP_SLVERR 2'b10

`define PFM_CODE_R1_SEQ 8'h20
`define PFM_CODE_R1_ON 8'h21
`define PFM_CODE_R1_ARMED 8'h22
`define PFM_CODE_R1_S5 8'h23
`define PFM_CODE_R2_SEQ 8'h30
`define PFM_CODE_R2_ON 8'h31
`define PFM_CODE_R2_ARMED 8'h32
`define PFM_CODE_R2_S5 8'h33
`define PFM_CODE_R3_SEQ 8'h40
`define PFM_CODE_R3_ON 8'h41
`define PFM_CODE_R3_S5 8'h43

`define PFM_CLK_KHZ 10000
`define PFM_START_MS 11'd2000
`define PFM_ONE_MS 11'd1000
`define PFM_ZERO_MS 11'd500
`define PFM_GAP_MS 11'd500
`define PFM_PG_TIMEOUT_MS 11'd1000
`define PFM_FLASH_MS 11'd500

`endif

// ==== src/pfm_pkg.sv ====
// Types shared by the power fault monitor: platform states, blink phases, bus channels.
// Assumes an AXI4-Lite master with 32-bit data.
package pfm_pkg;

    typedef enum logic [1:0] {
        PFM_PWR_SOFT_OFF = 2'h0,
        PFM_PWR_WAKE_ARMED = 2'h1,
        PFM_PWR_SEQUENCE = 2'h2,
        PFM_PWR_ON = 2'h3
    } pfm_pwr_state_t;

    typedef enum {
        PFM_BL_IDLE,
        PFM_BL_START,
        PFM_BL_ON,
        PFM_BL_GAP
    } pfm_blink_t;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } pfm_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pfm_axi_rsp_t;

endpackage

// ==== dv/pfm_rail_model.sv ====
// Behavioural model of the three switched rails and their power-good pins.
// Assumes the bench may override any pin to provoke the monitor's fault checks.
`timescale 1ns/100ps
`default_nettype none

module pfm_rail_model #(
    parameter int DLY = 100
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Enable from the monitor and bench overrides.
    input wire logic rail_enable_request,
    input wire logic [2:0] ovr_en,
    input wire logic [2:0] ovr_val,
    // Power-good pins.
    output logic first_rail_power_good,
    output logic second_rail_power_good,
    output logic third_rail_power_good
);
    int cnt_q;
    logic [2:0] up;

    // Rails rise one after another; a dropped enable collapses all at once.
    always_ff @(posedge clock) begin
        if (srst || !rail_enable_request) begin
            cnt_q <= 0;
        end else if (cnt_q < 3 * DLY) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign up = {cnt_q >= 3 * DLY, cnt_q >= 2 * DLY, cnt_q >= DLY};
    assign first_rail_power_good = ovr_en[0] ? ovr_val[0] : up[0];
    assign second_rail_power_good = ovr_en[1] ? ovr_val[1] : up[1];
    assign third_rail_power_good = ovr_en[2] ? ovr_val[2] : up[2];
endmodule // pfm_rail_model
`default_nettype wire

// ==== dv/pfm_top_tb.sv ====
// Self-checking bench for the power fault monitor: bus, lamps, faults, blink frame.
// Assumes the rail model beside it; the millisecond tick is shortened to 2 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "pfm_map.svh"

module pfm_top_tb
    import pfm_pkg::*;
;
    localparam int MS = 2;
    logic clock = 1'b0;
    logic srst = 1'b1;
    pfm_axi_req_t axi_req = '0;
    pfm_axi_rsp_t axi_rsp;
    logic [2:0] ovr_en = 3'h0;
    logic [2:0] ovr_val = 3'h0;
    logic pg1, pg2, pg3, en, lw, la, lp;
    logic [1:0] rsp;
    logic [31:0] rd;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int bad = 0;

    pfm_top #(.CYC_PER_MS(MS)) i_pfm_top (
        .clock(clock), .srst(srst), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .first_rail_power_good(pg1), .second_rail_power_good(pg2),
        .third_rail_power_good(pg3), .rail_enable_request(en),
        .supply_charge_lamp_white(lw), .supply_charge_lamp_amber(la),
        .power_lamp_white(lp));
    pfm_rail_model i_pfm_rail_model (
        .clock(clock), .srst(srst), .rail_enable_request(en), .ovr_en(ovr_en),
        .ovr_val(ovr_val), .first_rail_power_good(pg1),
        .second_rail_power_good(pg2), .third_rail_power_good(pg3));

    initial begin
        forever #50 clock = ~clock;
    end

    // A hung handshake or lamp wait ends the run here as a mismatch.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Lamp times are in ticks of two cycles, so a few cycles of slack are allowed.
    task automatic near(input string what, input int exp, input int got);
        num_checks++;
        if (got < exp - 4 || got > exp + 4) begin
            n_errors++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        bit aw, w;
        int t;
        aw = 0;
        w = 0;
        t = 0;
        @(posedge clock);
        axi_req.awaddr <= a;
        axi_req.wdata <= d;
        axi_req.wstrb <= s;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        while (t == 0) begin
            @(posedge clock);
            if (!aw && axi_rsp.awready === 1'b1) begin
                aw = 1;
                axi_req.awvalid <= 1'b0;
            end
            if (!w && axi_rsp.wready === 1'b1) begin
                w = 1;
                axi_req.wvalid <= 1'b0;
            end
            if (axi_rsp.bvalid === 1'b1) begin
                rsp = axi_rsp.bresp;
                axi_req.bready <= 1'b0;
                t = 1;
            end
        end
        chk("write answer", 32'h0, 32'({axi_req.awvalid, axi_req.wvalid}));
    endtask

    task automatic rdr(input logic [31:0] a);
        int t;
        t = 0;
        @(posedge clock);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        while (t == 0) begin
            @(posedge clock);
            if (axi_req.arvalid && axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
            if (axi_rsp.rvalid === 1'b1) begin
                rd = axi_rsp.rdata;
                rsp = axi_rsp.rresp;
                axi_req.rready <= 1'b0;
                t = 1;
            end
        end
        chk("read answer", 32'h0, 32'(axi_req.arvalid));
    endtask

    task automatic ctl(input logic [7:0] v);
        wr(`PFM_OFS_CTRL, {24'h0, v}, 4'hf);
    endtask

    task automatic run(input bit amb, input logic lvl, output int n);
        n = 0;
        while (((amb ? la : lw) === lvl) && n < 12000) begin
            if (!amb && la !== 1'b0) bad++;
            @(posedge clock);
            n++;
        end
    endtask

    task automatic t_bus();
        chk("outputs after reset", 32'h0, 32'({en, lw, la, lp}));
        rdr(`PFM_OFS_CTRL);
        chk("ctrl reset", {24'h0, `PFM_CTRL_RST}, rd);
        rdr(32'h8);
        chk("unmapped read resp", 32'(`PFM_RESP_SLVERR), 32'(rsp));
        chk("unmapped read data", 32'h0, rd);
        wr(32'hc, 32'h8c, 4'hf);
        chk("unmapped write resp", 32'(`PFM_RESP_SLVERR), 32'(rsp));
        wr(`PFM_OFS_CTRL, 32'h8c, 4'he);
        wr(`PFM_OFS_STATUS, 32'h1ff, 4'hf);
        chk("status write resp", 32'(`PFM_RESP_OKAY), 32'(rsp));
        rdr(`PFM_OFS_CTRL);
        chk("ctrl without strobe", 32'h0, rd);
        rdr(`PFM_OFS_STATUS);
        chk("status read only", 32'h0, rd);
        $display("bus test done");
    endtask

    task automatic t_lamps();
        logic [7:0] cv[5] = '{8'h8c, 8'h94, 8'h80, 8'h83, 8'h03};
        logic [2:0] ev[5] = '{3'b010, 3'b100, 3'b000, 3'b001, 3'b000};
        int n;
        for (int i = 0; i < 5; i++) begin
            ctl(cv[i]);
            wt(4);
            chk("lamps", 32'(ev[i]), 32'({lw, la, lp}));
        end
        ctl(8'ha0);
        // The flash runs free, so skip to a clean falling edge before timing it.
        run(1, 1'b0, n);
        run(1, 1'b1, n);
        run(1, 1'b0, n);
        near("amber flash off", 500 * MS, n);
        run(1, 1'b1, n);
        near("amber flash on", 500 * MS, n);
        chk("white while low", 32'h0, 32'(lw));
        $display("lamp test done");
    endtask

    task automatic t_frame();
        logic [7:0] c;
        int n;
        c = `PFM_CODE_R1_ON;
        ctl(8'hc2);
        wt(2200);
        chk("rail enable", 32'h1, 32'(en));
        rdr(`PFM_OFS_STATUS);
        chk("rails up", 32'he00, rd);
        ctl(8'hcf);
        wt(4);
        chk("on lamps", 32'h3, 32'({lw, la, lp}));
        ovr_val <= 3'b110;
        ovr_en <= 3'b111;
        wt(20);
        rdr(`PFM_OFS_STATUS);
        chk("fault while on", {24'h00000d, c}, rd);
        chk("amber in fault", 32'h0, 32'(la));
        bad = 0;
        run(0, 1'b0, n);
        for (int i = 0; i < 9; i++) begin
            run(0, 1'b1, n);
            near("bit on time", c[i % 8] ? 1000 * MS : 500 * MS, n);
            if (i < 8) begin
                run(0, 1'b0, n);
                near("off time", i == 7 ? 2500 * MS : 500 * MS, n);
            end
        end
        chk("amber during code", 32'h0, 32'(bad));
        ovr_val <= 3'b100;
        wt(20);
        rdr(`PFM_OFS_STATUS);
        chk("first fault kept", {24'h000009, c}, rd);
        ctl(8'h02);
        wt(4);
        rdr(`PFM_OFS_STATUS);
        chk("fault cleared", {24'h000008, c}, rd);
        chk("white after clear", 32'h0, 32'(lw));
        $display("frame test done");
    endtask

    task automatic t_events();
        logic [1:0] sv[8] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
        int rv[8] = '{1, 2, 0, 1, 2, 0, 1, 2};
        logic [7:0] cv[8] = '{`PFM_CODE_R2_ON, `PFM_CODE_R3_ON, `PFM_CODE_R1_ARMED,
            `PFM_CODE_R2_ARMED, 8'h00, `PFM_CODE_R1_S5, `PFM_CODE_R2_S5, `PFM_CODE_R3_S5};
        logic pre;
        logic [7:0] lc;
        logic [8:0] ex;
        // The code field keeps the last latched code when no new fault arrives.
        lc = 8'h00;
        for (int i = 0; i < 8; i++) begin
            pre = (sv[i] != 2'h0);
            ovr_val <= {3{pre}};
            ctl(8'h82);
            wt(10);
            ctl({6'h20, sv[i]});
            ovr_val[rv[i]] <= ~pre;
            wt(20);
            rdr(`PFM_OFS_STATUS);
            ex = (cv[i] != 8'h00) ? {1'b1, cv[i]} : {1'b0, lc};
            chk("event code", 32'(ex), 32'(rd[8:0]));
            if (cv[i] != 8'h00) begin
                lc = cv[i];
            end
            ctl(8'h02);
        end
        $display("event test done");
    endtask

    task automatic t_timeout();
        logic [2:0] pv[3] = '{3'b000, 3'b101, 3'b011};
        logic [7:0] cv[3] = '{`PFM_CODE_R1_SEQ, `PFM_CODE_R2_SEQ, `PFM_CODE_R3_SEQ};
        logic [7:0] lc;
        // The code field still holds the last code that the event test latched.
        lc = `PFM_CODE_R3_S5;
        for (int i = 0; i < 3; i++) begin
            ovr_val <= pv[i];
            ctl(8'hc2);
            wt(1900);
            rdr(`PFM_OFS_STATUS);
            chk("no early timeout", {24'h0, lc}, {23'h0, rd[8:0]});
            wt(300);
            rdr(`PFM_OFS_STATUS);
            chk("timeout code", {24'h000001, cv[i]}, {23'h0, rd[8:0]});
            lc = cv[i];
            ctl(8'h02);
        end
        $display("timeout test done");
    endtask

    initial begin
        wt(3);
        srst <= 1'b0;
        t_bus();
        t_lamps();
        t_frame();
        t_events();
        t_timeout();
        finish_test();
    end
endmodule // pfm_top_tb
`default_nettype wire
